/* serial_adc_glue.sv */
// Serial-triggered converter glue: receiver, start timing, transmitter.
// Assumes an AXI4-Lite master on clk_sys_i and an 8-bit SAR converter.
// Function
// - A complete received character raises the flag, starting a conversion.
// - The flag is retimed on the converter clock before driving start low.
// - Converter busy rises on the ninth falling converter clock edge.
// - Busy rising edge loads the 8-bit result toward the transmitter.
// - Load stays asserted until the transmitter takes the data.
// - Load never drops before buffer empty; held data is never overwritten.
// - Buffer empty also clears the received flag for the next trigger.
// - Serial timing runs from a clock enable at sixteen times bit rate.
// - Converter and serial clocks are independent, unrelated dividers.
// - Length, parity inhibit, even parity, stop bits are static settings.
// - A delayed power-up reset holds the serial part before use.
// - The loaded result is sent back serially as one character.
`timescale 1ns/10ps
`default_nettype none
`include "serial_adc_consts.svh"
module serial_adc_glue #(
  parameter int PUR_CYCLES =
    (`PUR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // AXI4-Lite register slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial line
  input wire logic serial_rx_in_i,
  output logic serial_tx_out_o,
  // Converter pins
  output logic conv_clk_o,
  output logic conv_start_n_o,
  input wire logic conv_busy_n_i,
  input wire logic [7:0] conv_data_i
);
  generate
    if (PUR_CYCLES < 1 || PUR_CYCLES > 65535) begin : g_bad_pur
      $error("PUR_CYCLES must lie between 1 and 65535");
    end
    if (FIFO_DEPTH > 8) begin : g_bad_depth
      $error("FIFO_DEPTH above 8 does not fit the level field");
    end
  endgenerate

  serial_adc_pkg::glue_state_s s_reg;
  serial_adc_pkg::glue_state_s s_next;
  logic rst_meta_n_reg;
  logic rst_n_reg;
  logic fifo_in_ready;
  logic tx_buffer_load;
  logic [7:0] tx_holding_latch;
  logic tx_buffer_empty;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
  logic aw_go;
  logic ar_go;
  logic [31:0] wr_merged;
  logic [31:0] rd_value;
  logic [3:0] nb;

  function automatic logic [3:0] len_of(input logic [1:0] sel);
    len_of = 4'h5 + {2'h0, sel};
  endfunction : len_of

  function automatic logic [7:0] len_mask(input logic [1:0] sel);
    len_mask = 8'hff >> (2'h3 - sel);
  endfunction : len_mask

  function automatic logic par_of(input logic [7:0] d, input logic even);
    par_of = (^d) ^ !even;
  endfunction : par_of

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_n_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_n_reg <= rst_meta_n_reg;
    end
  end

  sample_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_reg),
    .in_valid_i(s_reg.push),
    .in_data_i(s_reg.last_result),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(tx_buffer_load),
    .out_data_o(tx_holding_latch),
    .out_ready_i(tx_buffer_empty),
    .level_o(fifo_level)
  );

  // Load held by the FIFO until the idle transmitter takes it
  assign tx_buffer_empty = s_reg.tx_state == serial_adc_pkg::TX_IDLE
    && s_reg.enable && s_reg.pur_done;
  assign nb = len_of(s_reg.cfg[1:0]) + {3'h0, !s_reg.cfg[2]};
  assign aw_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_reg.bvalid;
  assign ar_go = s_axi_arvalid_i && !s_reg.rvalid;
  assign s_axi_awready_o = aw_go;
  assign s_axi_wready_o = aw_go;
  assign s_axi_arready_o = ar_go;
  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign s_axi_rdata_o = s_reg.rdata;
  assign s_axi_rresp_o = s_reg.rresp;
  assign serial_tx_out_o = s_reg.tx_out;
  assign conv_clk_o = s_reg.conv_clk;
  assign conv_start_n_o = s_reg.start_n;

  always_comb begin
    rd_value = 32'h0;
    case (s_axi_araddr_i)
      `CTRL_OFS: rd_value = {23'h0, s_reg.enable, 3'h0, s_reg.cfg};
      `BAUD_OFS: rd_value = {16'h0, s_reg.baud_div};
      `CONV_OFS: rd_value = {24'h0, s_reg.conv_half};
      `STAT_OFS: begin
        rd_value[`ST_FLAG_BIT] = s_reg.rx_char_flag;
        rd_value[`ST_BUSY_BIT] = s_reg.cv_state != serial_adc_pkg::CV_IDLE;
        rd_value[`ST_TXE_BIT] = tx_buffer_empty;
        rd_value[`ST_PERR_BIT] = s_reg.parity_err;
        rd_value[`ST_FERR_BIT] = s_reg.frame_err;
        rd_value[`ST_OVR_BIT] = s_reg.overrun;
        rd_value[`ST_LATE_BIT] = s_reg.eoc_late;
        rd_value[`ST_LVL_LSB +: 4] = 4'(fifo_level);
        rd_value[`ST_RXC_LSB +: 8] = s_reg.rx_char;
      end
      `DATA_OFS: rd_value = {24'h0, s_reg.last_result};
      default: rd_value = 32'h0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    wr_merged = 32'h0;
    s_next.tick = 1'b0;
    s_next.conv_rise = 1'b0;
    s_next.conv_fall = 1'b0;
    s_next.push = 1'b0;
    // Pins from outside the clock domain
    s_next.rx_meta = serial_rx_in_i;
    s_next.rx_sync = s_reg.rx_meta;
    s_next.busy_meta = conv_busy_n_i;
    s_next.busy_sync = s_reg.busy_meta;
    s_next.busy_prev = s_reg.busy_sync;
    s_next.data_meta = conv_data_i;
    s_next.data_sync = s_reg.data_meta;
    // Delayed power-up reset for the serial part
    if (!s_reg.pur_done) begin
      if (s_reg.pur_cnt == 16'(PUR_CYCLES - 1)) begin
        s_next.pur_done = 1'b1;
      end else begin
        s_next.pur_cnt = s_reg.pur_cnt + 16'h1;
      end
    end
    // Sixteen-times bit rate enable
    if (s_reg.tick_div + 16'h1 >= s_reg.baud_div) begin
      s_next.tick_div = 16'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_div = s_reg.tick_div + 16'h1;
    end
    // Converter clock from its own unrelated divider
    if (s_reg.conv_div + 8'h1 >= s_reg.conv_half) begin
      s_next.conv_div = 8'h0;
      s_next.conv_clk = !s_reg.conv_clk;
      s_next.conv_rise = !s_reg.conv_clk;
      s_next.conv_fall = s_reg.conv_clk;
    end else begin
      s_next.conv_div = s_reg.conv_div + 8'h1;
    end
    // Register writes; clears come first so a same-cycle event wins
    if (aw_go) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      case (s_axi_awaddr_i)
        `CTRL_OFS: begin
          wr_merged = merge({23'h0, s_reg.enable, 3'h0, s_reg.cfg},
                            s_axi_wdata_i, s_axi_wstrb_i);
          s_next.cfg = wr_merged[4:0];
          s_next.enable = wr_merged[`CTRL_EN_BIT];
        end
        `BAUD_OFS: begin
          wr_merged = merge({16'h0, s_reg.baud_div}, s_axi_wdata_i,
                            s_axi_wstrb_i);
          s_next.baud_div = wr_merged[15:0];
        end
        `CONV_OFS: begin
          wr_merged = merge({24'h0, s_reg.conv_half}, s_axi_wdata_i,
                            s_axi_wstrb_i);
          s_next.conv_half = wr_merged[7:0];
        end
        `STAT_OFS: begin
          if (s_axi_wstrb_i[0]) begin
            if (s_axi_wdata_i[`ST_PERR_BIT]) s_next.parity_err = 1'b0;
            if (s_axi_wdata_i[`ST_FERR_BIT]) s_next.frame_err = 1'b0;
            if (s_axi_wdata_i[`ST_OVR_BIT]) s_next.overrun = 1'b0;
            if (s_axi_wdata_i[`ST_LATE_BIT]) s_next.eoc_late = 1'b0;
          end
        end
        `DATA_OFS: s_next.bresp = `RESP_OKAY;
        default: s_next.bresp = `RESP_SLVERR;
      endcase
    end else if (s_reg.bvalid && s_axi_bready_i) begin
      s_next.bvalid = 1'b0;
    end
    if (ar_go) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_value;
      s_next.rresp = (s_axi_araddr_i > `DATA_OFS
        || s_axi_araddr_i[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_reg.rvalid && s_axi_rready_i) begin
      s_next.rvalid = 1'b0;
    end
    // Transmitter accepting the held word clears the trigger flag
    if (tx_buffer_load && tx_buffer_empty) begin
      s_next.rx_char_flag = 1'b0;
    end
    // Conversion sequencing on the converter clock
    case (s_reg.cv_state)
      serial_adc_pkg::CV_IDLE: begin
        // Retimed on converter clock; waits while the FIFO is full
        if (s_reg.conv_rise && s_reg.rx_char_flag && fifo_in_ready
            && s_reg.enable) begin
          s_next.start_n = 1'b0;
          s_next.cv_state = serial_adc_pkg::CV_RUN;
          s_next.fall_cnt = 4'h0;
        end
      end
      serial_adc_pkg::CV_RUN: begin
        if (s_reg.conv_rise) begin
          s_next.start_n = 1'b1;
        end
        if (s_reg.conv_fall && s_reg.fall_cnt != 4'hf) begin
          s_next.fall_cnt = s_reg.fall_cnt + 4'h1;
        end
        if (s_reg.busy_sync && !s_reg.busy_prev && s_reg.start_n) begin
          s_next.push = 1'b1;
          s_next.last_result = s_reg.data_sync;
          s_next.cv_state = serial_adc_pkg::CV_DONE;
          // Sync delay may add one edge, so allow nine or ten
          if (s_reg.fall_cnt < `EOC_FALL_EDGES
              || s_reg.fall_cnt > `EOC_FALL_EDGES + 4'h1) begin
            s_next.eoc_late = 1'b1;
          end
        end
      end
      serial_adc_pkg::CV_DONE: begin
        if (!s_reg.rx_char_flag) begin
          s_next.cv_state = serial_adc_pkg::CV_IDLE;
        end
      end
      default: s_next.cv_state = serial_adc_pkg::CV_IDLE;
    endcase
    // Receiver
    if (s_reg.tick) begin
      case (s_reg.rx_state)
        serial_adc_pkg::RX_IDLE: begin
          if (!s_reg.rx_sync && s_reg.pur_done && s_reg.enable) begin
            s_next.rx_state = serial_adc_pkg::RX_START;
            s_next.rx_sub = 4'h0;
          end
        end
        serial_adc_pkg::RX_START: begin
          s_next.rx_sub = s_reg.rx_sub + 4'h1;
          if (s_reg.rx_sub == 4'h7) begin
            s_next.rx_sub = 4'h0;
            s_next.rx_bit = 4'h0;
            s_next.rx_state = s_reg.rx_sync ? serial_adc_pkg::RX_IDLE
                                            : serial_adc_pkg::RX_BITS;
          end
        end
        serial_adc_pkg::RX_BITS: begin
          s_next.rx_sub = s_reg.rx_sub + 4'h1;
          if (s_reg.rx_sub == 4'hf) begin
            s_next.rx_shift[s_reg.rx_bit] = s_reg.rx_sync;
            s_next.rx_bit = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == nb - 4'h1) begin
              s_next.rx_state = serial_adc_pkg::RX_STOP;
            end
          end
        end
        serial_adc_pkg::RX_STOP: begin
          s_next.rx_sub = s_reg.rx_sub + 4'h1;
          if (s_reg.rx_sub == 4'hf) begin
            s_next.rx_state = serial_adc_pkg::RX_IDLE;
            s_next.rx_char = s_reg.rx_shift[7:0] & len_mask(s_reg.cfg[1:0]);
            if (!s_reg.rx_sync) s_next.frame_err = 1'b1;
            if (!s_reg.cfg[2] && s_reg.rx_shift[len_of(s_reg.cfg[1:0])]
                != par_of(s_reg.rx_shift[7:0] & len_mask(s_reg.cfg[1:0]),
                          s_reg.cfg[3])) begin
              s_next.parity_err = 1'b1;
            end
            if (s_reg.rx_char_flag) s_next.overrun = 1'b1;
            s_next.rx_char_flag = 1'b1;
          end
        end
        default: s_next.rx_state = serial_adc_pkg::RX_IDLE;
      endcase
    end
    // Transmitter; the accepted word is framed as one character
    case (s_reg.tx_state)
      serial_adc_pkg::TX_IDLE: begin
        if (tx_buffer_load && tx_buffer_empty) begin
          s_next.tx_shift = {1'b1,
                             tx_holding_latch & len_mask(s_reg.cfg[1:0])};
          s_next.tx_shift[len_of(s_reg.cfg[1:0])] = s_reg.cfg[2] ? 1'b1 :
            par_of(tx_holding_latch & len_mask(s_reg.cfg[1:0]), s_reg.cfg[3]);
          s_next.tx_state = serial_adc_pkg::TX_START;
          s_next.tx_sub = 4'h0;
          s_next.tx_out = 1'b0;
        end
      end
      serial_adc_pkg::TX_START: begin
        if (s_reg.tick) begin
          s_next.tx_sub = s_reg.tx_sub + 4'h1;
          if (s_reg.tx_sub == 4'hf) begin
            s_next.tx_bit = 4'h0;
            s_next.tx_out = s_reg.tx_shift[0];
            s_next.tx_state = serial_adc_pkg::TX_BITS;
          end
        end
      end
      serial_adc_pkg::TX_BITS: begin
        if (s_reg.tick) begin
          s_next.tx_sub = s_reg.tx_sub + 4'h1;
          if (s_reg.tx_sub == 4'hf) begin
            s_next.tx_bit = s_reg.tx_bit + 4'h1;
            s_next.tx_out = s_reg.tx_shift[s_reg.tx_bit + 4'h1];
            if (s_reg.tx_bit == nb - 4'h1) begin
              s_next.tx_out = 1'b1;
              s_next.tx_bit = 4'h0;
              s_next.tx_state = serial_adc_pkg::TX_STOP;
            end
          end
        end
      end
      serial_adc_pkg::TX_STOP: begin
        if (s_reg.tick) begin
          s_next.tx_sub = s_reg.tx_sub + 4'h1;
          if (s_reg.tx_sub == 4'hf) begin
            s_next.tx_bit = 4'h1;
            if (!s_reg.cfg[4] || s_reg.tx_bit != 4'h0) begin
              s_next.tx_state = serial_adc_pkg::TX_IDLE;
            end
          end
        end
      end
      default: s_next.tx_state = serial_adc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      s_reg <= '0;
      s_reg.start_n <= 1'b1;
      s_reg.rx_meta <= 1'b1;
      s_reg.rx_sync <= 1'b1;
      // Busy idles high; a low reset value would fake an end edge
      s_reg.busy_meta <= 1'b1;
      s_reg.busy_sync <= 1'b1;
      s_reg.busy_prev <= 1'b1;
      s_reg.tx_out <= 1'b1;
      s_reg.cv_state <= serial_adc_pkg::CV_IDLE;
      s_reg.rx_state <= serial_adc_pkg::RX_IDLE;
      s_reg.tx_state <= serial_adc_pkg::TX_IDLE;
      s_reg.cfg <= `CFG_RST;
      s_reg.enable <= 1'b1;
      s_reg.baud_div <= `BAUD_RST;
      s_reg.conv_half <= `CONV_RST;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : serial_adc_glue
`default_nettype wire

/* serial_adc_consts.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes a 10 MHz system clock and an 8-bit register address.
`ifndef SERIAL_ADC_CONSTS_SVH
`define SERIAL_ADC_CONSTS_SVH

`define CTRL_OFS 8'h00
`define BAUD_OFS 8'h04
`define CONV_OFS 8'h08
`define STAT_OFS 8'h0c
`define DATA_OFS 8'h10

`define CTRL_EN_BIT 8
`define ST_FLAG_BIT 0
`define ST_BUSY_BIT 1
`define ST_TXE_BIT 2
`define ST_PERR_BIT 3
`define ST_FERR_BIT 4
`define ST_OVR_BIT 5
`define ST_LATE_BIT 6
`define ST_LVL_LSB 8
`define ST_RXC_LSB 16

`define CFG_RST 5'h03
`define BAUD_RST 16'h0041
`define CONV_RST 8'h0a

`define CLK_PERIOD_NS 100
`define PUR_TIME_NS 1000000
`define OVERSAMPLE 16
`define EOC_FALL_EDGES 4'h9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* serial_adc_pkg.sv */
// Types shared by the serial converter glue.
// Assumes nothing beyond a SystemVerilog elaborator.
package serial_adc_pkg;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_START = 4'h2, TX_BITS = 4'h4, TX_STOP = 4'h8
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_BITS = 4'h4, RX_STOP = 4'h8
  } rx_state_e;

  typedef enum logic [2:0] {
    CV_IDLE = 3'h1, CV_RUN = 3'h2, CV_DONE = 3'h4
  } conv_state_e;

  typedef struct packed {
    logic [15:0] pur_cnt;
    logic pur_done;
    logic [15:0] tick_div;
    logic tick;
    logic [7:0] conv_div;
    logic conv_clk;
    logic conv_rise;
    logic conv_fall;
    logic rx_meta;
    logic rx_sync;
    logic busy_meta;
    logic busy_sync;
    logic busy_prev;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic rx_char_flag;
    logic start_n;
    conv_state_e cv_state;
    logic [3:0] fall_cnt;
    logic eoc_late;
    logic push;
    logic [7:0] last_result;
    rx_state_e rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [7:0] rx_char;
    tx_state_e tx_state;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_out;
    logic parity_err;
    logic frame_err;
    logic overrun;
    logic [4:0] cfg;
    logic enable;
    logic [15:0] baud_div;
    logic [7:0] conv_half;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } glue_state_s;

endpackage : serial_adc_pkg

/* sample_fifo.sv */
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sample_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_state_s;

  fifo_state_s s_reg;
  fifo_state_s s_next;
  logic do_push;
  logic do_pop;

  assign in_ready_o = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = s_reg.mem[s_reg.rd];
  assign level_o = ($clog2(DEPTH+1))'(s_reg.cnt);
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (do_push) begin
      s_next.mem[s_reg.wr] = in_data_i;
      s_next.wr = s_reg.wr + AW'(1);
    end
    if (do_pop) begin
      s_next.rd = s_reg.rd + AW'(1);
    end
    if (do_push && !do_pop) begin
      s_next.cnt = s_reg.cnt + (AW+1)'(1);
    end else if (do_pop && !do_push) begin
      s_next.cnt = s_reg.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : sample_fifo
`default_nettype wire

/* conv_model.sv */
// Behavioural 8-bit successive approximation converter.
// Assumes the glue drives its clock and active-low start pin.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
  // Converter pins
  input wire logic conv_clk_i,
  input wire logic start_n_i,
  output logic busy_n_o,
  output logic [7:0] data_o,
  // Result the bench wants next
  input wire logic [7:0] value_i
);
  int falls = 0;
  logic [7:0] held = 8'h00;
  initial begin
    busy_n_o = 1'b1;
    data_o = 8'h00;
  end
  // Data toggles while busy, so an early sample is caught
  always @(negedge conv_clk_i) begin
    if (!start_n_i) begin
      busy_n_o <= 1'b0;
      held <= value_i;
      falls <= 0;
    end else if (!busy_n_o) begin
      falls <= falls + 1;
      data_o <= (falls == 8) ? held : ~data_o;
      busy_n_o <= (falls == 8);
    end
  end
endmodule : conv_model
`default_nettype wire

/* serial_adc_glue_asserts.sv */
// Port checks for the serial converter glue.
// Assumes binding onto serial_adc_glue by port name.
`timescale 1ns/10ps
`default_nettype none
module serial_adc_glue_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  // Serial line and converter
  input wire logic serial_rx_in_i,
  input wire logic serial_tx_out_o,
  input wire logic conv_clk_o,
  input wire logic conv_start_n_o,
  input wire logic conv_busy_n_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic rx_seen, pending, eoc_seen;
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_seen <= 1'b0;
      pending <= 1'b0;
      eoc_seen <= 1'b0;
    end else begin
      rx_seen <= rx_seen | !serial_rx_in_i;
      eoc_seen <= eoc_seen | $rose(conv_busy_n_i);
      // Cleared when the reply frame starts
      if ($fell(conv_start_n_o)) pending <= 1'b1;
      else if ($fell(serial_tx_out_o)) pending <= 1'b0;
    end
  end
  AST_START_ON_CLK: assert property (
    $fell(conv_start_n_o) |-> conv_clk_o) else $error("start off clock");
  AST_STOP_ON_CLK: assert property (
    $rose(conv_start_n_o) |-> conv_clk_o) else $error("stop off clock");
  AST_START_LEN: assert property (
    $fell(conv_start_n_o) |-> !conv_start_n_o[*8] ##[1:32] conv_start_n_o)
    else $error("start pulse length wrong");
  AST_START_CAUSE: assert property (
    $fell(conv_start_n_o) |-> rx_seen) else $error("start without char");
  AST_ONE_PER_FLAG: assert property (
    $fell(conv_start_n_o) |-> !pending) else $error("second start");
  AST_EOC_TO_TX: assert property (
    $rose(conv_busy_n_i) |-> ##[2:200] $fell(serial_tx_out_o))
    else $error("result not sent");
  AST_TX_CAUSE: assert property (
    $fell(serial_tx_out_o) |-> eoc_seen) else $error("frame before result");
  AST_CCLK_HALF: assert property (
    $rose(conv_clk_o) |-> conv_clk_o[*8] ##[1:8] !conv_clk_o)
    else $error("converter clock half period wrong");
  AST_WR_RESP: assert property (
    s_axi_awvalid_i && s_axi_awready_o |=> s_axi_bvalid_o)
    else $error("no write response");
  AST_RD_RESP: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read response");
  COV_START: cover property ($fell(conv_start_n_o));
  COV_EOC: cover property ($rose(conv_busy_n_i));
  COV_WR: cover property (s_axi_bvalid_o);
endmodule : serial_adc_glue_asserts
bind serial_adc_glue serial_adc_glue_asserts u_asserts (.*);
`default_nettype wire

/* serial_adc_glue_tb.sv */
// Bench: remote host on the serial line, software on AXI4-Lite.
// Assumes conv_model as converter and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "serial_adc_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
`define WAIT(c) begin n = 0; do begin @(posedge clk_sys_i); n++; \
  if (n > 3000) hang(); end while ((c) !== 1'b1); end
module serial_adc_glue_tb;
  localparam int BAUD = 4;
  localparam int BIT = 16 * BAUD;
  localparam logic [7:0] RA [5] = '{`CTRL_OFS, `BAUD_OFS, `CONV_OFS,
    8'h14, 8'h02};
  localparam logic [31:0] RV [5] = '{(32'h1 << `CTRL_EN_BIT) | `CFG_RST,
    {16'h0, `BAUD_RST}, {24'h0, `CONV_RST}, 32'h0, 32'h0};
  localparam logic [1:0] RR [5] = '{`RESP_OKAY, `RESP_OKAY, `RESP_OKAY,
    `RESP_SLVERR, `RESP_SLVERR};
  localparam logic [4:0] FMT [5] = '{5'h03, 5'h00, 5'h09, 5'h16, 5'h1b};
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, value = 8'h00, cdata;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [1:0] bresp, rresp, rr;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, rx = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, tx, cclk, start_n, busy_n;
  int error_cnt = 0, n_tests = 0, n, len, par, even, two;
  logic [7:0] exp_q[$];
  serial_adc_glue #(.PUR_CYCLES(4), .FIFO_DEPTH(8)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .serial_rx_in_i(rx), .serial_tx_out_o(tx), .conv_clk_o(cclk),
    .conv_start_n_o(start_n), .conv_busy_n_i(busy_n), .conv_data_i(cdata));
  conv_model u_conv (.conv_clk_i(cclk), .start_n_i(start_n),
    .busy_n_o(busy_n), .data_o(cdata), .value_i(value));
  task automatic conclude;
    $display("%0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic hang;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    `WAIT(awready && wready)
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    `WAIT(bvalid)
    bready <= 1'b0;
    `CHK(bresp, e)
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    `WAIT(arready)
    arvalid <= 1'b0;
    `WAIT(rvalid)
    rready <= 1'b0;
    rdv = rdata;
    rr = rresp;
  endtask : rd
  task automatic put(input logic b);
    rx <= b;
    repeat (BIT) @(posedge clk_sys_i);
  endtask : put
  function automatic logic [7:0] mask;
    return 8'((9'h001 << len) - 9'h001);
  endfunction : mask
  function automatic logic parity(input logic [7:0] v);
    return even ? ^(v & mask()) : ~^(v & mask());
  endfunction : parity
  task automatic round(input logic [4:0] cfg);
    logic [7:0] got, v;
    len = 5 + cfg[1:0];
    par = !cfg[2];
    even = cfg[3];
    two = cfg[4];
    wr(`CTRL_OFS, {23'h0, 1'b1, 3'h0, cfg}, `RESP_OKAY);
    v = 8'($urandom);
    value <= v;
    exp_q.push_back(v);
    got = 8'($urandom);
    put(1'b0);
    for (int i = 0; i < len; i++) put(got[i]);
    if (par) put(parity(got));
    repeat (two + 1) put(1'b1);
    `WAIT(tx === 1'b0)
    repeat (BIT / 2) @(posedge clk_sys_i);
    `CHK(tx, 1'b0)
    for (int i = 0; i < len; i++) begin
      repeat (BIT) @(posedge clk_sys_i);
      got[i] = tx;
    end
    v = exp_q.pop_front();
    `CHK(got & mask(), v & mask())
    if (par) begin
      repeat (BIT) @(posedge clk_sys_i);
      `CHK(tx, parity(v))
    end
    for (int i = 0; i <= two; i++) begin
      repeat (BIT) @(posedge clk_sys_i);
      `CHK(tx, 1'b1)
    end
    rd(`DATA_OFS);
    `CHK(rdv[7:0], v)
    rd(`STAT_OFS);
    `CHK(rdv[0], 1'b0)
    `CHK(rdv[6:3], 4'h0)
    $display("round with format %h done", cfg);
  endtask : round
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    void'($urandom(17251));
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    `CHK(tx, 1'b1)
    `CHK(start_n, 1'b1)
    for (int i = 0; i < 5; i++) begin
      rd(RA[i]);
      `CHK(rdv, RV[i])
      `CHK(rr, RR[i])
    end
    wr(8'h14, 32'h0000005a, `RESP_SLVERR);
    $display("reset and register test done");
    wr(`BAUD_OFS, 32'(BAUD), `RESP_OKAY);
    foreach (FMT[i]) round(FMT[i]);
    for (int i = 0; i < 4; i++) round(5'($urandom));
    conclude();
  end
endmodule : serial_adc_glue_tb
`default_nettype wire
